// File: fast_clock_cal.sv
// fast-clock ratio measurement, trim register and fine led timing of the sensing front end
// assumes slow_osc_in is the free-running 32 kHz time base, asynchronous to clk_sys
//
// Behaviour
// [RULE1] led pulse width and spacing are counted in trimmed fast-clock cycles
// [RULE2] host calibrates the slow time base before the fast one
// [RULE3] host sets buffer access enable before calibrating
// [RULE4] setting measure enable starts the ratio measurement
// [RULE5] ratio counts fast cycles across two slow-clock periods
// [RULE6] count appears in bits 11:0 of the read-only ratio register
// [RULE7] tuned oscillators give the nominal count 0x7D0
// [RULE8] host computes frequency error from the ratio against 2000
// [RULE9] host writes trim to bits 7:0; device shifts fast frequency accordingly
// [RULE10] host clears enable after trimming; clearing resets the ratio function
// [RULE11] host repeats enable, compute, trim, clear until accurate enough
// [RULE12] host clears buffer access enable and restores interrupt pin afterwards
// [RULE13] slow clock paces sampling; fast clock paces fine processing timing
// [RULE14] ratio holds last count while enabled; each enable rise remeasures
`timescale 1ns/1ps
`default_nettype none
module fast_clock_cal #(
  parameter int LED_PULSES = 1
) (
  // clock and reset
  input  wire logic                           clk_sys,
  input  wire logic                           reset,
  // register access behind the serial interface
  input  wire fast_clock_cal_pkg::reg_req_t   reg_req,
  output logic [15:0]                         reg_rdata_ff,
  output logic                                reg_rvalid_ff,
  // slow oscillator
  input  wire logic                           slow_osc_in,
  // timing outputs
  output logic                                sample_tick_ff,
  output logic                                led_drive_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // slow clock synchroniser and edge detect

  logic slow_sync1_ff;
  logic slow_sync2_ff;
  logic slow_prev_ff;
  logic slow_rise;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      slow_sync1_ff <= 1'b0;
      slow_sync2_ff <= 1'b0;
      slow_prev_ff  <= 1'b0;
    end else begin
      slow_sync1_ff <= slow_osc_in;
      slow_sync2_ff <= slow_sync1_ff;
      slow_prev_ff  <= slow_sync2_ff;
    end
  end

  assign slow_rise = slow_sync2_ff & ~slow_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [fast_clock_cal_pkg::TRIM_W-1:0]  fast_osc_trim_value_ff;
  logic                                   fast_osc_measure_enable_ff;
  logic                                   buffer_access_enable_ff;
  logic [fast_clock_cal_pkg::RATIO_W-1:0] ratio_result_ff;
  logic [fast_clock_cal_pkg::TRIM_W-1:0]  nxt_trim;
  logic                                   nxt_measure_enable;
  logic                                   nxt_buffer_access;
  logic [15:0]                            nxt_rdata;
  logic                                   nxt_rvalid;

  always_comb begin
    nxt_trim           = fast_osc_trim_value_ff;
    nxt_measure_enable = fast_osc_measure_enable_ff;
    nxt_buffer_access  = buffer_access_enable_ff;
    nxt_rdata          = reg_rdata_ff;
    nxt_rvalid         = reg_req.rd;
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        fast_clock_cal_pkg::ADDR_FAST_TRIM: begin
          nxt_trim = reg_req.wdata[fast_clock_cal_pkg::TRIM_W-1:0]; // [RULE9]
        end
        fast_clock_cal_pkg::ADDR_CAL_CONTROL: begin
          nxt_measure_enable = reg_req.wdata[fast_clock_cal_pkg::MEASURE_ENABLE_BIT]; // [RULE4]
        end
        fast_clock_cal_pkg::ADDR_BUFFER_ACCESS: begin
          nxt_buffer_access = reg_req.wdata[fast_clock_cal_pkg::BUFFER_ACCESS_BIT];
        end
        default: begin
          // writes elsewhere, including the read-only ratio, are dropped
        end
      endcase
    end
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        fast_clock_cal_pkg::ADDR_RATIO_RESULT: begin
          nxt_rdata = {4'h0, ratio_result_ff}; // [RULE6]
        end
        fast_clock_cal_pkg::ADDR_FAST_TRIM: begin
          nxt_rdata = {8'h00, fast_osc_trim_value_ff};
        end
        fast_clock_cal_pkg::ADDR_CAL_CONTROL: begin
          nxt_rdata = 16'(fast_osc_measure_enable_ff) << fast_clock_cal_pkg::MEASURE_ENABLE_BIT;
        end
        fast_clock_cal_pkg::ADDR_BUFFER_ACCESS: begin
          nxt_rdata = 16'(buffer_access_enable_ff) << fast_clock_cal_pkg::BUFFER_ACCESS_BIT;
        end
        default: begin
          nxt_rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fast_osc_trim_value_ff     <= fast_clock_cal_pkg::TRIM_RESET;
      fast_osc_measure_enable_ff <= 1'b0;
      buffer_access_enable_ff    <= 1'b0;
      reg_rdata_ff               <= 16'h0000;
      reg_rvalid_ff              <= 1'b0;
    end else begin
      fast_osc_trim_value_ff     <= nxt_trim;
      fast_osc_measure_enable_ff <= nxt_measure_enable;
      buffer_access_enable_ff    <= nxt_buffer_access;
      reg_rdata_ff               <= nxt_rdata;
      reg_rvalid_ff              <= nxt_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trimmed fast oscillator

  logic fast_tick;

  fast_osc_nco #(
    .NCO_BITS     (fast_clock_cal_pkg::NCO_W)
  ) u_fast_osc (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .trim         (fast_osc_trim_value_ff),
    .fast_tick_ff (fast_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // ratio measurement

  fast_clock_cal_pkg::ratio_state_t       ratio_state_ff;
  fast_clock_cal_pkg::ratio_state_t       nxt_ratio_state;
  logic [fast_clock_cal_pkg::RATIO_W-1:0] ratio_count_ff;
  logic [fast_clock_cal_pkg::RATIO_W-1:0] nxt_ratio_count;
  logic [fast_clock_cal_pkg::RATIO_W-1:0] nxt_ratio_result;
  logic [1:0]                             slow_periods_ff;
  logic [1:0]                             nxt_slow_periods;

  always_comb begin
    nxt_ratio_state  = ratio_state_ff;
    nxt_ratio_count  = ratio_count_ff;
    nxt_ratio_result = ratio_result_ff;
    nxt_slow_periods = slow_periods_ff;
    unique case (ratio_state_ff)
      fast_clock_cal_pkg::RATIO_IDLE: begin
        if (fast_osc_measure_enable_ff) begin
          nxt_ratio_state = fast_clock_cal_pkg::RATIO_WAIT_EDGE; // [RULE4] [RULE14]
        end
      end
      fast_clock_cal_pkg::RATIO_WAIT_EDGE: begin
        nxt_ratio_count  = '0;
        nxt_slow_periods = '0;
        if (slow_rise) begin
          nxt_ratio_state = fast_clock_cal_pkg::RATIO_COUNT;
        end
      end
      fast_clock_cal_pkg::RATIO_COUNT: begin
        // saturate rather than wrap so a badly slow time base reads as full scale
        if (fast_tick && ratio_count_ff != '1) begin
          nxt_ratio_count = ratio_count_ff + 1'b1; // [RULE5]
        end
        if (slow_rise) begin
          nxt_slow_periods = slow_periods_ff + 1'b1;
          if (slow_periods_ff == 2'(fast_clock_cal_pkg::RATIO_SLOW_PERIODS - 1)) begin
            nxt_ratio_result = nxt_ratio_count; // [RULE5] [RULE6] [RULE7]
            nxt_ratio_state  = fast_clock_cal_pkg::RATIO_DONE;
          end
        end
      end
      fast_clock_cal_pkg::RATIO_DONE: begin
        // result stays put until enable is cleared and set again
      end
    endcase
    if (!fast_osc_measure_enable_ff) begin
      nxt_ratio_state  = fast_clock_cal_pkg::RATIO_IDLE; // [RULE10]
      nxt_ratio_count  = '0;
      nxt_slow_periods = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ratio_state_ff  <= fast_clock_cal_pkg::RATIO_IDLE;
      ratio_count_ff  <= fast_clock_cal_pkg::RATIO_RESET;
      ratio_result_ff <= fast_clock_cal_pkg::RATIO_RESET;
      slow_periods_ff <= 2'h0;
    end else begin
      ratio_state_ff  <= nxt_ratio_state;
      ratio_count_ff  <= nxt_ratio_count;
      ratio_result_ff <= nxt_ratio_result;
      slow_periods_ff <= nxt_slow_periods;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample pacing and led pulse train

  logic [fast_clock_cal_pkg::LED_CNT_W-1:0] led_cnt_ff;
  logic [fast_clock_cal_pkg::LED_CNT_W-1:0] nxt_led_cnt;
  logic [7:0]                               pulses_left_ff;
  logic [7:0]                               nxt_pulses_left;
  logic                                     nxt_led_drive;

  always_comb begin
    nxt_led_cnt     = led_cnt_ff;
    nxt_pulses_left = pulses_left_ff;
    if (slow_rise) begin
      // each rising slow edge opens a sample; the burst inside it runs on fast cycles
      nxt_pulses_left = 8'(LED_PULSES); // [RULE13]
      nxt_led_cnt     = '0;
    end else if (fast_tick && pulses_left_ff != 8'h00) begin
      if (led_cnt_ff == fast_clock_cal_pkg::LED_CNT_W'(fast_clock_cal_pkg::LED_PERIOD_CYC - 1)) begin
        nxt_led_cnt     = '0;
        nxt_pulses_left = pulses_left_ff - 1'b1;
      end else begin
        nxt_led_cnt = led_cnt_ff + 1'b1; // [RULE1]
      end
    end
    nxt_led_drive = (nxt_pulses_left != 8'h00)
                  && (nxt_led_cnt < fast_clock_cal_pkg::LED_CNT_W'(fast_clock_cal_pkg::LED_WIDTH_CYC)); // [RULE1]
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      led_cnt_ff     <= '0;
      pulses_left_ff <= 8'h00;
      led_drive_ff   <= 1'b0;
      sample_tick_ff <= 1'b0;
    end else begin
      led_cnt_ff     <= nxt_led_cnt;
      pulses_left_ff <= nxt_pulses_left;
      led_drive_ff   <= nxt_led_drive;
      sample_tick_ff <= slow_rise; // [RULE13]
    end
  end

endmodule
`default_nettype wire

// File: fast_clock_cal_pkg.sv
// constants, register map and carrier types of the fast-clock ratio calibration block
// assumes a 100 MHz system clock and an external register access agent that issues one-cycle strobes
package fast_clock_cal_pkg;

  // system clock and fast oscillator model
  localparam longint CLK_SYS_HZ     = 100_000_000;
  localparam longint FAST_NOM_HZ    = 32_000_000;
  localparam longint SLOW_NOM_HZ    = 32_000;
  localparam longint TRIM_STEP_HZ   = 109_000;
  localparam int     NCO_W          = 24;
  localparam logic [NCO_W-1:0] NCO_NOM_INC =
    NCO_W'((FAST_NOM_HZ << NCO_W) / CLK_SYS_HZ);
  localparam logic [NCO_W-1:0] NCO_STEP_INC =
    NCO_W'((TRIM_STEP_HZ << NCO_W) / CLK_SYS_HZ);

  // register offsets
  localparam logic [6:0] ADDR_RATIO_RESULT   = 7'h0A;
  localparam logic [6:0] ADDR_FAST_TRIM      = 7'h4D;
  localparam logic [6:0] ADDR_CAL_CONTROL    = 7'h50;
  localparam logic [6:0] ADDR_BUFFER_ACCESS  = 7'h5F;

  // field positions and widths
  localparam int RATIO_W            = 12;
  localparam int TRIM_W             = 8;
  localparam int MEASURE_ENABLE_BIT = 5;
  localparam int BUFFER_ACCESS_BIT  = 0;

  // values after reset and nominal figures
  localparam logic [RATIO_W-1:0] RATIO_RESET   = 12'h000;
  localparam logic [RATIO_W-1:0] RATIO_NOMINAL = 12'h7D0;
  localparam logic [TRIM_W-1:0]  TRIM_RESET    = 8'h00;
  localparam int                 RATIO_SLOW_PERIODS = 2;

  // fine timing of the led pulse train, in fast-clock cycles
  localparam longint LED_WIDTH_NS   = 3_000;
  localparam longint LED_PERIOD_NS  = 19_000;
  localparam int     LED_WIDTH_CYC  = int'((LED_WIDTH_NS * FAST_NOM_HZ) / 1_000_000_000);
  localparam int     LED_PERIOD_CYC = int'((LED_PERIOD_NS * FAST_NOM_HZ) / 1_000_000_000);
  localparam int     LED_CNT_W      = 10;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [6:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    RATIO_IDLE,
    RATIO_WAIT_EDGE,
    RATIO_COUNT,
    RATIO_DONE
  } ratio_state_t;

endpackage

// File: fast_clock_cal_props.sv
// assertions on the ports of the fast-clock calibration block
// assumes one clk_sys domain with synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module fast_clock_cal_props (
  // clock and reset
  input wire logic                         clk_sys,
  input wire logic                         reset,
  // register port
  input wire fast_clock_cal_pkg::reg_req_t reg_req,
  input wire logic [15:0]                  reg_rdata_ff,
  input wire logic                         reg_rvalid_ff,
  // timing
  input wire logic                         slow_osc_in,
  input wire logic                         sample_tick_ff,
  input wire logic                         led_drive_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic [9:0] hi_ff;
  logic [9:0] nxt_hi;
  ////////////////////////////////////////
  // led pulse length in clk_sys cycles
  always_comb nxt_hi = led_drive_ff ? hi_ff + 10'h001 : 10'h000;
  always_ff @(posedge clk_sys) hi_ff <= reset ? 10'h000 : nxt_hi;
  a_read_answer: assert property (reg_req.rd |=> reg_rvalid_ff)
    else $error("read not answered");
  a_answer_cause: assert property (reg_rvalid_ff |-> $past(reg_req.rd))
    else $error("answer without read");
  a_rdata_holds: assert property (!reg_rvalid_ff && !$past(reset) |-> $stable(reg_rdata_ff))
    else $error("read data moved");
  a_ratio_upper: assert property (reg_rvalid_ff && $past(reg_req.addr) == 7'h0A |-> reg_rdata_ff[15:12] == 4'h0)
    else $error("ratio upper bits set");
  a_enable_field: assert property (reg_rvalid_ff && $past(reg_req.addr) == 7'h50 |-> (reg_rdata_ff & 16'hFFDF) == 16'h0000)
    else $error("control stray bits");
  a_trim_field: assert property (reg_rvalid_ff && $past(reg_req.addr) == 7'h4D |-> reg_rdata_ff[15:8] == 8'h00)
    else $error("trim stray bits");
  a_slow_tick: assert property ($rose(slow_osc_in) |-> ##[2:5] sample_tick_ff)
    else $error("slow edge gave no tick");
  a_tick_pulse: assert property (sample_tick_ff |=> !sample_tick_ff)
    else $error("tick longer than one cycle");
  a_led_width: assert property ($fell(led_drive_ff) && !$past(reset) |-> hi_ff >= 10'h10E && hi_ff <= 10'h14A)
    else $error("led pulse width off");
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> !reg_rvalid_ff && !sample_tick_ff && !led_drive_ff)
    else $error("outputs active in reset");
endmodule
bind fast_clock_cal fast_clock_cal_props u_props (.clk_sys(clk_sys), .reset(reset), .reg_req(reg_req),
  .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff), .slow_osc_in(slow_osc_in),
  .sample_tick_ff(sample_tick_ff), .led_drive_ff(led_drive_ff));
`default_nettype wire

// File: fast_clock_cal_tb_top.sv
// self-checking bench of the fast-clock ratio calibration block
// assumes the slow time base model drives slow_osc_in
`timescale 1ns/1ps
`default_nettype none
module fast_clock_cal_tb_top;
  typedef struct packed {
    logic [6:0]  addr;
    logic [15:0] wdata;
    logic [15:0] exp;
  } row_t;
  localparam row_t ROWS [5] = '{'{7'h0A, 16'hFFFF, 16'h0000}, '{7'h33, 16'hFFFF, 16'h0000},
    '{7'h4D, 16'h1234, 16'h0034}, '{7'h5F, 16'hFFFF, 16'h0001}, '{7'h50, 16'hFFDF, 16'h0000}};
  localparam logic [7:0] TRIMS [2] = '{8'h14, 8'hEC};
  localparam longint CYC2 = fast_clock_cal_pkg::CLK_SYS_HZ * fast_clock_cal_pkg::RATIO_SLOW_PERIODS
    / fast_clock_cal_pkg::SLOW_NOM_HZ;
  logic                         clk_sys;
  logic                         reset;
  fast_clock_cal_pkg::reg_req_t reg_req;
  logic [15:0]                  rdata;
  logic                         rvalid;
  logic                         slow;
  logic                         tick;
  logic                         led;
  int                           err_count;
  int                           total_checks;
  int                           w;
  logic [15:0]                  d;
  logic [15:0]                  held;
  longint                       corr;
  fast_clock_cal DUT (.clk_sys(clk_sys), .reset(reset), .reg_req(reg_req), .reg_rdata_ff(rdata),
    .reg_rvalid_ff(rvalid), .slow_osc_in(slow), .sample_tick_ff(tick), .led_drive_ff(led));
  slow_osc_model u_slow (.slow_osc(slow));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one strobe, then an idle edge, so no edge is driven twice
  task automatic access(input logic wr, input logic [6:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_req <= '{wr: wr, rd: !wr, addr: a, wdata: v};
    @(posedge clk_sys);
    reg_req <= '0;
    #1;
    if (!wr) begin
      check("rvalid", {15'h0000, rvalid}, 16'h0001);
      d = rdata;
    end
  endtask
  task automatic wait_ticks(input int n);
    int seen;
    seen = 0;
    for (int i = 0; i < 20000 && seen < n; i++) begin
      @(posedge clk_sys);
      #1;
      if (tick === 1'b1) seen++;
    end
    if (seen < n) begin
      err_count++;
      report_and_stop();
    end
  endtask
  // nco tick count over two slow periods; jitter allows one count either way
  task automatic check_ratio(input logic [7:0] t);
    longint inc;
    logic [15:0] e;
    inc = longint'(fast_clock_cal_pkg::NCO_NOM_INC);
    inc = inc + longint'($signed(t)) * longint'(fast_clock_cal_pkg::NCO_STEP_INC);
    e = 16'((inc * CYC2) >> fast_clock_cal_pkg::NCO_W);
    access(1'b0, 7'h0A, 16'h0000);
    check("ratio", {15'h0000, d + 16'h0001 >= e && d <= e + 16'h0001}, 16'h0001);
  endtask
  ////////////////////////////////////////
  initial begin
    reset = 1'b1;
    reg_req = '0;
    err_count = 0;
    total_checks = 0;
    repeat (9) @(posedge clk_sys);
    #1;
    check("quiet", {13'h0000, rvalid, tick, led}, 16'h0000);
    @(posedge clk_sys);
    reset <= 1'b0;
    access(1'b0, 7'h4D, 16'h0000);
    check("trim_reset", d, 16'h0000);
    foreach (ROWS[i]) begin
      access(1'b1, ROWS[i].addr, ROWS[i].wdata);
      access(1'b0, ROWS[i].addr, 16'h0000);
      check("row_read", d, ROWS[i].exp);
    end
    $display("register table done");
    access(1'b1, 7'h4D, 16'h0000);
    access(1'b1, 7'h5F, 16'h0001);
    access(1'b1, 7'h50, 16'h0020);
    access(1'b0, 7'h50, 16'h0000);
    check("enable", d, 16'h0020);
    wait_ticks(4);
    check_ratio(8'h00);
    held = d;
    w = 0;
    for (int i = 0; i < 4000 && led === 1'b1; i++) begin @(posedge clk_sys); #1; end
    for (int i = 0; i < 4000 && led !== 1'b1; i++) begin @(posedge clk_sys); #1; end
    while (led === 1'b1 && w < 1000) begin @(posedge clk_sys); #1; w++; end
    check("led_width", {15'h0000, w >= 297 && w <= 303}, 16'h0001);
    wait_ticks(1);
    access(1'b0, 7'h0A, 16'h0000);
    check("ratio_hold", d, held);
    $display("nominal measurement done");
    foreach (TRIMS[k]) begin
      access(1'b1, 7'h4D, {8'h00, TRIMS[k]});
      access(1'b1, 7'h50, 16'h0000);
      access(1'b0, 7'h0A, 16'h0000);
      check("ratio_after_clear", d, held);
      access(1'b1, 7'h50, 16'h0020);
      wait_ticks(4);
      check_ratio(TRIMS[k]);
      corr = fast_clock_cal_pkg::FAST_NOM_HZ * (longint'(fast_clock_cal_pkg::RATIO_NOMINAL) - longint'(d))
        / (longint'(fast_clock_cal_pkg::RATIO_NOMINAL) * fast_clock_cal_pkg::TRIM_STEP_HZ);
      // the host's correction should undo the trim it measures, to within one step
      check("trim_estimate", {15'h0000, corr + longint'($signed(TRIMS[k])) inside {[-1:1]}}, 16'h0001);
      held = d;
    end
    access(1'b1, 7'h50, 16'h0000);
    access(1'b1, 7'h5F, 16'h0000);
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    access(1'b0, 7'h0A, 16'h0000);
    check("ratio_reset", d, 16'h0000);
    access(1'b0, 7'h4D, 16'h0000);
    check("trim_reset2", d, 16'h0000);
    $display("trim and reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire

// File: fast_osc_nco.sv
// trimmable model of the internal fast oscillator: a phase accumulator on clk_sys
// assumes clk_sys well above the fast frequency so one tick per cycle at most
`timescale 1ns/1ps
`default_nettype none
module fast_osc_nco #(
  parameter int NCO_BITS = fast_clock_cal_pkg::NCO_W
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  // trim, two's complement steps
  input  wire logic [7:0]           trim,
  // one-cycle pulse per fast-clock cycle
  output logic                      fast_tick_ff
);

  logic [NCO_BITS-1:0] acc_ff;
  logic [NCO_BITS-1:0] nxt_acc;
  logic                nxt_fast_tick;
  logic [NCO_BITS-1:0] inc;
  logic [NCO_BITS:0]   sum;

  always_comb begin
    // each trim step moves the fast frequency by one step size
    inc           = NCO_BITS'(fast_clock_cal_pkg::NCO_NOM_INC
                    + NCO_BITS'($signed(trim)) * fast_clock_cal_pkg::NCO_STEP_INC); // [RULE9]
    sum           = {1'b0, acc_ff} + {1'b0, inc};
    nxt_acc       = sum[NCO_BITS-1:0];
    nxt_fast_tick = sum[NCO_BITS];
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      acc_ff       <= '0;
      fast_tick_ff <= 1'b0;
    end else begin
      acc_ff       <= nxt_acc;
      fast_tick_ff <= nxt_fast_tick;
    end
  end

endmodule
`default_nettype wire

// File: slow_osc_model.sv
// free-running slow time base, already calibrated to its nominal rate
// assumes a 1 ns time unit; runs free, as the real oscillator does
`timescale 1ns/1ps
`default_nettype none
module slow_osc_model (
  // slow clock level
  output var logic slow_osc
);
  localparam real HALF_NS = 1.0e9 / (2.0 * fast_clock_cal_pkg::SLOW_NOM_HZ);
  ////////////////////////////////////////
  // odd offset keeps edges off the clk_sys grid
  initial begin
    slow_osc = 1'b0;
    #3.3;
    forever #(HALF_NS) slow_osc = ~slow_osc;
  end
endmodule
`default_nettype wire
